// file: src/ccd_mon.sv
// Column-command spacing monitor per bank group and preamble mode
`timescale 1ns/1ps
module ccd_mon (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       col,
    input  wire logic       is_wr,
    input  wire logic [1:0] bg,
    input  wire logic       rpre2,
    input  wire logic       wpre2,
    input  wire logic       crc,
    output logic            bad5,
    output logic            badl,
    output logic [1:0]      last_bg
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       seen;
        logic [1:0] bg;
        logic       b5;
        logic       bl;
    } mon_s;
    mon_s       st_r;
    mon_s       st_nxt;
    logic [3:0] gap;

    always_comb begin
        st_nxt    = st_r;
        // Saturated count stands for a long gap; wrapping to zero would flag a false violation
        gap       = (st_r.cnt == 4'hF) ? 4'hF : st_r.cnt + 4'h1;
        st_nxt.b5 = 1'b0;
        st_nxt.bl = 1'b0;
        if (tick) begin
            if (st_r.cnt != 4'hF) st_nxt.cnt = gap;
            if (col) begin
                if (st_r.seen) begin
                    st_nxt.b5 = (!is_wr && rpre2 && gap == ddr_pre_pkg::CCD_BAD) ||
                        (is_wr && wpre2 && gap == (crc ? ddr_pre_pkg::CCD_BAD_CRC
                                                       : ddr_pre_pkg::CCD_BAD));
                    st_nxt.bl = (bg == st_r.bg) ? (gap < ddr_pre_pkg::CCD_L_CK)
                                                : (gap < ddr_pre_pkg::CCD_S_CK);
                end
                st_nxt.cnt  = 4'h0;
                st_nxt.seen = 1'b1;
                st_nxt.bg   = bg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bad5    = st_r.b5;
    assign badl    = st_r.bl;
    assign last_bg = st_r.bg;
endmodule : ccd_mon

// file: src/ddr_pre_pkg.sv
// Shared constants, command layout and register map for the preamble block
package ddr_pre_pkg;
    localparam logic [7:0]  A_CTRL       = 8'h00;
    localparam logic [7:0]  A_STAT       = 8'h04;
    localparam logic [7:0]  A_PAT        = 8'h08;
    localparam logic [7:0]  A_WDAT       = 8'h0C;
    localparam int          C_MPR        = 0;
    localparam int          C_X16        = 1;
    localparam int          C_CRC        = 2;
    localparam int          C_BC4        = 3;
    localparam int          C_CL         = 4;
    localparam int          C_PAGE       = 9;
    localparam logic [4:0]  CL_RST       = 5'h0B;
    localparam logic [31:0] PAT_RST      = 32'h0000_0000;
    localparam int          S_CCD5       = 0;
    localparam int          S_CCDL       = 1;
    localparam int          MR4_WPRE     = 12;
    localparam int          MR4_RPRE     = 11;
    localparam int          MR4_TRAIN    = 10;
    localparam int          MR2_CWL      = 3;
    localparam logic [2:0]  MR_SEL4      = 3'h4;
    localparam logic [2:0]  MR_SEL2      = 3'h2;
    localparam logic [2:0]  CMD_MRS      = 3'h0;
    localparam logic [2:0]  CMD_RD       = 3'h5;
    localparam logic [2:0]  CMD_WR       = 3'h4;
    localparam logic [3:0]  CCD_S_CK     = 4'h4;
    localparam logic [3:0]  CCD_L_CK     = 4'h4;
    localparam logic [3:0]  CCD_BAD      = 4'h5;
    localparam logic [3:0]  CCD_BAD_CRC  = 4'h6;
    localparam logic [3:0]  BL8_HALVES   = 4'h8;
    localparam logic [3:0]  BC4_HALVES   = 4'h4;
    localparam logic [4:0]  PRE1_CK      = 5'h1;
    localparam logic [4:0]  PRE2_CK      = 5'h2;
    localparam logic [4:0]  CWL_MIN_2CK  = 5'h0E;

    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [13:0] a;
    } cmd_s;

    function automatic logic [4:0] cwl_of(input logic [2:0] c);
        case (c)
            3'h0: cwl_of = 5'h09;
            3'h1: cwl_of = 5'h0A;
            3'h2: cwl_of = 5'h0B;
            3'h3: cwl_of = 5'h0C;
            3'h4: cwl_of = 5'h0E;
            3'h5: cwl_of = 5'h10;
            3'h6: cwl_of = 5'h12;
            default: cwl_of = 5'h14;
        endcase
    endfunction : cwl_of
endpackage : ddr_pre_pkg

// file: src/ddr_pre_top.sv
// Top level: preamble modes, read preamble training and bank groups behind APB
`timescale 1ns/1ps
module ddr_pre_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ck,
    input  wire logic        cs_n,
    input  wire logic        act_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [1:0]  bg,
    input  wire logic [1:0]  ba,
    input  wire logic [13:0] addr,
    input  wire logic        dqs_t_in,
    input  wire logic        dqs_c_in,
    output logic             dqs_t_out,
    output logic             dqs_c_out,
    output logic             dqs_oe,
    input  wire logic [7:0]  dq_in,
    output logic [7:0]       dq_out,
    output logic             dq_oe,
    output logic             wr_win
);
    typedef struct packed {
        logic [2:0]        ck_s;
        ddr_pre_pkg::cmd_s c1;
        ddr_pre_pkg::cmd_s c2;
        logic [7:0]        d1;
        logic [7:0]        d2;
        logic [1:0]        q1;
        logic [1:0]        q2;
        logic              q3;
        logic              mpr;
        logic              x16;
        logic              crc;
        logic              bc4;
        logic [4:0]        cl;
        logic [1:0]        page;
        logic              wpre2;
        logic              rpre2;
        logic              train;
        logic [2:0]        cwl;
        logic              s_ccd5;
        logic              s_ccdl;
        logic [1:0]        act_bg;
        logic [1:0]        act_ba;
        logic [1:0]        rba;
        logic [31:0]       pat;
        logic [7:0]        wdat;
        logic              wcap;
        logic [31:0]       rsch;
        logic [31:0]       wsch;
        logic              dqs_t;
        logic              dqs_c;
        logic              dqs_oe;
        logic [7:0]        dq;
        logic              dq_oe;
        logic              wr_win;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } top_s;

    top_s        st_r;
    top_s        st_nxt;
    strobe_if    rif ();
    strobe_if    wif ();
    logic        rise;
    logic        fall;
    logic        sel;
    logic [2:0]  code;
    logic        is_act;
    logic        is_mrs;
    logic        is_rd;
    logic        is_wr;
    logic        rd_ok;
    logic        train_act;
    logic        srise;
    logic [1:0]  ebg;
    logic [4:0]  rpre;
    logic [4:0]  wpre;
    logic [4:0]  rlat;
    logic [4:0]  wlat;
    logic [7:0]  rbyte;
    logic        setup;
    logic        wr_acc;
    logic [31:0] rdv;
    logic        hit;
    logic        bad5;
    logic        badl;
    logic [1:0]  col_bg;
    logic        cwl_short;

    // Pin-side decode; every command-link pin is seen only after two flip-flops, APB inputs are decoded directly
    always_comb begin
        rise      = st_r.ck_s[1] & ~st_r.ck_s[2];
        fall      = ~st_r.ck_s[1] & st_r.ck_s[2];
        sel       = rise & ~st_r.c2.cs_n;
        code      = {st_r.c2.ras_n, st_r.c2.cas_n, st_r.c2.we_n};
        is_act    = sel & ~st_r.c2.act_n;
        is_mrs    = sel & st_r.c2.act_n & (code == ddr_pre_pkg::CMD_MRS);
        is_rd     = sel & st_r.c2.act_n & (code == ddr_pre_pkg::CMD_RD);
        is_wr     = sel & st_r.c2.act_n & (code == ddr_pre_pkg::CMD_WR);
        train_act = st_r.train & st_r.mpr;
        // While training only page-0 register reads release the strobes
        rd_ok     = is_rd & ~(train_act & (st_r.page != 2'h0));
        ebg       = st_r.x16 ? {1'b0, st_r.c2.bg[0]} : st_r.c2.bg;
        rpre      = st_r.rpre2 ? ddr_pre_pkg::PRE2_CK : ddr_pre_pkg::PRE1_CK;
        wpre      = st_r.wpre2 ? ddr_pre_pkg::PRE2_CK : ddr_pre_pkg::PRE1_CK;
        // Preamble is launched early so data lands on the latency edge
        rlat      = (st_r.cl > rpre) ? (st_r.cl - rpre - 5'h1) : 5'h0;
        wlat      = ddr_pre_pkg::cwl_of(st_r.cwl) - wpre - 5'h1;
        cwl_short = st_r.wpre2 && (ddr_pre_pkg::cwl_of(st_r.cwl) < ddr_pre_pkg::CWL_MIN_2CK);
        rbyte     = st_r.pat[{st_r.rba, 3'b000} +: 8];
        srise     = st_r.q2[1] & ~st_r.q3 & ~st_r.q2[0];
        setup     = psel & ~penable;
        wr_acc    = psel & penable & st_r.pready & pwrite;
    end

    assign rif.tick   = rise | fall;
    assign rif.start  = rise & st_r.rsch[0];
    assign rif.pre2   = st_r.rpre2;
    assign rif.halves = st_r.bc4 ? ddr_pre_pkg::BC4_HALVES : ddr_pre_pkg::BL8_HALVES;
    assign wif.tick   = rise | fall;
    assign wif.start  = rise & st_r.wsch[0];
    assign wif.pre2   = st_r.wpre2;
    assign wif.halves = st_r.bc4 ? ddr_pre_pkg::BC4_HALVES : ddr_pre_pkg::BL8_HALVES;

    strobe_seq u_rd_seq (
        .clk (clk),
        .rst (rst),
        .sif (rif)
    );

    // Write side reuses the sequencer as the expected receive window
    strobe_seq u_wr_seq (
        .clk (clk),
        .rst (rst),
        .sif (wif)
    );

    ccd_mon u_ccd (
        .clk     (clk),
        .rst     (rst),
        .tick    (rise),
        .col     (is_rd | is_wr),
        .is_wr   (is_wr),
        .bg      (ebg),
        .rpre2   (st_r.rpre2),
        .wpre2   (st_r.wpre2),
        .crc     (st_r.crc),
        .bad5    (bad5),
        .badl    (badl),
        .last_bg (col_bg)
    );

    // Register read view
    always_comb begin
        rdv = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr)
            ddr_pre_pkg::A_CTRL: begin
                rdv[ddr_pre_pkg::C_MPR]       = st_r.mpr;
                rdv[ddr_pre_pkg::C_X16]       = st_r.x16;
                rdv[ddr_pre_pkg::C_CRC]       = st_r.crc;
                rdv[ddr_pre_pkg::C_BC4]       = st_r.bc4;
                rdv[ddr_pre_pkg::C_CL +: 5]   = st_r.cl;
                rdv[ddr_pre_pkg::C_PAGE +: 2] = st_r.page;
            end
            ddr_pre_pkg::A_STAT: begin
                rdv[14:0] = {col_bg, st_r.act_ba, st_r.act_bg, st_r.cwl, train_act,
                             st_r.rpre2, st_r.wpre2, cwl_short, st_r.s_ccdl, st_r.s_ccd5};
            end
            ddr_pre_pkg::A_PAT:  rdv = st_r.pat;
            ddr_pre_pkg::A_WDAT: rdv[7:0] = st_r.wdat;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.ck_s = {st_r.ck_s[1:0], ck};
        st_nxt.c1   = {cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr};
        st_nxt.c2   = st_r.c1;
        st_nxt.d1   = dq_in;
        st_nxt.d2   = st_r.d1;
        st_nxt.q1   = {dqs_t_in, dqs_c_in};
        st_nxt.q2   = st_r.q1;
        st_nxt.q3   = st_r.q2[1];

        // Mode register writes arriving on the command pins
        if (is_mrs && {st_r.c2.bg[0], st_r.c2.ba} == ddr_pre_pkg::MR_SEL4) begin
            st_nxt.wpre2 = st_r.c2.a[ddr_pre_pkg::MR4_WPRE];
            st_nxt.rpre2 = st_r.c2.a[ddr_pre_pkg::MR4_RPRE];
            st_nxt.train = st_r.c2.a[ddr_pre_pkg::MR4_TRAIN];
        end
        if (is_mrs && {st_r.c2.bg[0], st_r.c2.ba} == ddr_pre_pkg::MR_SEL2) begin
            st_nxt.cwl = st_r.c2.a[ddr_pre_pkg::MR2_CWL +: 3];
        end
        if (is_act) begin
            st_nxt.act_bg = ebg;
            st_nxt.act_ba = st_r.c2.ba;
        end

        // Latency schedulers, one bit per clock still to wait
        if (rise) begin
            st_nxt.rsch = st_r.rsch >> 1;
            st_nxt.wsch = st_r.wsch >> 1;
        end
        if (rd_ok) begin
            st_nxt.rsch[rlat] = 1'b1;
            st_nxt.rba        = st_r.c2.ba;
        end
        if (is_wr) begin
            st_nxt.wsch[wlat] = 1'b1;
        end

        // Read strobes and data; training holds strobes and data parked
        if (rif.drv) begin
            st_nxt.dqs_t  = rif.t_lvl;
            st_nxt.dqs_c  = ~rif.t_lvl;
            st_nxt.dqs_oe = 1'b1;
        end else begin
            st_nxt.dqs_t  = 1'b0;
            st_nxt.dqs_c  = train_act;
            st_nxt.dqs_oe = train_act;
        end
        st_nxt.dq_oe = rif.in_burst | train_act;
        st_nxt.dq    = rif.in_burst ? {8{rbyte[3'h7 - rif.beat]}} : 8'hFF;

        // Write window spans preamble, burst and the half-clock postamble
        st_nxt.wr_win = wif.drv;
        if (wif.start) st_nxt.wcap = 1'b0;
        if (wif.in_burst && srise && !st_r.wcap) begin
            st_nxt.wdat = st_r.d2;
            st_nxt.wcap = 1'b1;
        end

        // APB slave: answers in the first access cycle
        st_nxt.pready  = setup;
        st_nxt.pslverr = setup & ~hit;
        st_nxt.prdata  = (setup & ~pwrite) ? rdv : 32'h0000_0000;
        if (wr_acc && paddr == ddr_pre_pkg::A_CTRL) begin
            st_nxt.mpr  = pwdata[ddr_pre_pkg::C_MPR];
            st_nxt.x16  = pwdata[ddr_pre_pkg::C_X16];
            st_nxt.crc  = pwdata[ddr_pre_pkg::C_CRC];
            st_nxt.bc4  = pwdata[ddr_pre_pkg::C_BC4];
            st_nxt.cl   = pwdata[ddr_pre_pkg::C_CL +: 5];
            st_nxt.page = pwdata[ddr_pre_pkg::C_PAGE +: 2];
        end
        if (wr_acc && paddr == ddr_pre_pkg::A_PAT) begin
            st_nxt.pat = pwdata;
        end
        // Sticky flags: write one to clear, a new event in the same cycle wins
        if (wr_acc && paddr == ddr_pre_pkg::A_STAT) begin
            if (pwdata[ddr_pre_pkg::S_CCD5]) st_nxt.s_ccd5 = 1'b0;
            if (pwdata[ddr_pre_pkg::S_CCDL]) st_nxt.s_ccdl = 1'b0;
        end
        if (bad5) st_nxt.s_ccd5 = 1'b1;
        if (badl) st_nxt.s_ccdl = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r        <= '0;
            st_r.c1     <= '1;
            st_r.c2     <= '1;
            st_r.cl     <= ddr_pre_pkg::CL_RST;
            st_r.pat    <= ddr_pre_pkg::PAT_RST;
            st_r.dq     <= 8'hFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata    = st_r.prdata;
    assign pready    = st_r.pready;
    assign pslverr   = st_r.pslverr;
    assign dqs_t_out = st_r.dqs_t;
    assign dqs_c_out = st_r.dqs_c;
    assign dqs_oe    = st_r.dqs_oe;
    assign dq_out    = st_r.dq;
    assign dq_oe     = st_r.dq_oe;
    assign wr_win    = st_r.wr_win;
endmodule : ddr_pre_top

// file: src/strobe_if.sv
// Control and status bundle between the top level and a strobe sequencer
`timescale 1ns/1ps
interface strobe_if;
    logic       tick;
    logic       start;
    logic       pre2;
    logic [3:0] halves;
    logic       drv;
    logic       t_lvl;
    logic       in_burst;
    logic [2:0] beat;
    modport gen (input tick, start, pre2, halves, output drv, t_lvl, in_burst, beat);
    modport ctl (output tick, start, pre2, halves, input drv, t_lvl, in_burst, beat);
endinterface : strobe_if

// file: src/strobe_seq.sv
// Half-clock strobe sequencer: preamble, burst toggling, half-clock postamble
`timescale 1ns/1ps
module strobe_seq (
    input wire logic clk,
    input wire logic rst,
    strobe_if.gen    sif
);
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_PRE   = 2'b01,
        S_BURST = 2'b11,
        S_POST  = 2'b10
    } seq_e;
    typedef struct packed {
        seq_e       st;
        logic [3:0] cnt;
        logic       pend;
        logic       drv;
        logic       t;
        logic       inb;
        logic [2:0] beat;
    } seq_s;
    seq_s st_r;
    seq_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (sif.tick) begin
            unique case (st_r.st)
                S_IDLE, S_POST: begin
                    st_nxt.drv = 1'b0;
                    st_nxt.inb = 1'b0;
                    st_nxt.st  = S_IDLE;
                    if (sif.start) begin
                        st_nxt.st  = S_PRE;
                        st_nxt.drv = 1'b1;
                        st_nxt.t   = 1'b0;
                        st_nxt.cnt = sif.pre2 ? 4'h3 : 4'h1;
                    end
                end
                S_PRE: begin
                    st_nxt.cnt = st_r.cnt - 4'h1;
                    if (st_r.cnt == 4'h0) begin
                        st_nxt.st   = S_BURST;
                        st_nxt.inb  = 1'b1;
                        st_nxt.t    = 1'b1;
                        st_nxt.beat = 3'h0;
                        st_nxt.cnt  = sif.halves - 4'h1;
                    end
                end
                S_BURST: begin
                    st_nxt.t    = ~st_r.t;
                    st_nxt.beat = st_r.beat + 3'h1;
                    st_nxt.cnt  = st_r.cnt - 4'h1;
                    if (sif.start) st_nxt.pend = 1'b1;
                    if (st_r.cnt == 4'h0) begin
                        if (st_r.pend || sif.start) begin
                            // Back-to-back burst: the strobe keeps toggling, no preamble
                            st_nxt.t    = 1'b1;
                            st_nxt.beat = 3'h0;
                            st_nxt.cnt  = sif.halves - 4'h1;
                            st_nxt.pend = 1'b0;
                        end else begin
                            st_nxt.st  = S_POST;
                            st_nxt.t   = 1'b0;
                            st_nxt.inb = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '{st: S_IDLE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sif.drv      = st_r.drv;
    assign sif.t_lvl    = st_r.t;
    assign sif.in_burst = st_r.inb;
    assign sif.beat     = st_r.beat;
endmodule : strobe_seq

// file: tb/ddr_ctl_model.sv
// Memory controller model driving the command link
`timescale 1ns/1ps
module ddr_ctl_model (
    input wire logic    clk,
    output logic        ck,
    output logic        cs_n,
    output logic        act_n,
    output logic [2:0]  rcw,
    output logic [1:0]  bg,
    output logic [1:0]  ba,
    output logic [13:0] addr
);
    logic [1:0] ph;
    initial {ph, ck, cs_n, act_n, rcw, bg, ba, addr} = {2'h0, 1'b0, 1'b1, 1'b1, 3'h7, 18'h0};
    // Free-running CK of a fast grade, so two-clock preambles are legal
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3) begin
            ck <= ~ck;
        end
    end
    // Pins change at CK fall; gap in CK fixes spacing to the next command
    task issue(input logic an, input logic [2:0] c, input logic [1:0] g, input logic [1:0] b,
               input logic [13:0] a, input int gap);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            if (ph == 2'h3 && ck) break;
        end
        {cs_n, act_n, rcw, bg, ba, addr} <= {1'b0, an, c, g, b, a};
        repeat (8) @(posedge clk);
        // Deselected pins show the inverse, never a stale command
        {cs_n, act_n, rcw, bg, ba, addr} <= {1'b1, ~{an, c, g, b, a}};
        repeat (gap * 8 - 9) @(posedge clk);
    endtask : issue
endmodule : ddr_ctl_model

// file: tb/ddr_pre_sva.sv
// Port assertions for the preamble and training block
`timescale 1ns/1ps
module ddr_pre_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dqs_t_out,
    input wire logic        dqs_c_out,
    input wire logic        dqs_oe,
    input wire logic        dq_oe,
    input wire logic [7:0]  dq_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    // Preamble low for at least one full CK (8 clk)
    sequence pre_s;
        !dqs_t_out [*8];
    endsequence
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    setup_answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
    err_map_a: assert property (pready |-> pslverr == (|paddr[7:4] || |paddr[1:0])) else $error("bad pslverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
    strobe_pair_a: assert property (dqs_oe |-> dqs_c_out == !dqs_t_out) else $error("strobe pair not complementary");
    data_strobe_a: assert property (dq_oe |-> dqs_oe) else $error("data driven without strobe");
    lane_copy_a: assert property (dq_oe |-> dq_out == 8'hFF || dq_out == 8'h00) else $error("lanes differ");
    pre_len_a: assert property ($rose(dqs_oe) |-> pre_s) else $error("preamble too short");
    // Last burst half and the postamble are both low; a one-CK postamble would show low at depth 9
    read_post_a: assert property ($fell(dqs_oe) && !$past(dq_oe) |->
        !$past(dqs_t_out) && !$past(dqs_t_out, 8) && $past(dqs_t_out, 9)) else $error("postamble not half CK");
endmodule : ddr_pre_sva

// file: tb/tb.sv
// Bench: register access and command-link scenarios
`timescale 1ns/1ps
module tb;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr, dq_out;
    logic [31:0] pwdata, prdata, q;
    logic        ck, cs_n, act_n, dqs_t_out, dqs_c_out, dqs_oe, dq_oe, wr_win;
    logic [2:0]  rcw;
    logic [1:0]  bg, ba;
    logic [13:0] addr;
    int          failures, checks_done, k;
    always #50 clk = ~clk;
    ddr_ctl_model i_ctl (.clk(clk), .ck(ck), .cs_n(cs_n), .act_n(act_n), .rcw(rcw), .bg(bg), .ba(ba), .addr(addr));
    ddr_pre_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck(ck), .cs_n(cs_n),
        .act_n(act_n), .ras_n(rcw[2]), .cas_n(rcw[1]), .we_n(rcw[0]), .bg(bg), .ba(ba), .addr(addr),
        .dqs_t_in(ck), .dqs_c_in(~ck), .dq_in(8'h5A), .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out),
        .dqs_oe(dqs_oe), .dq_out(dq_out), .dq_oe(dq_oe), .wr_win(wr_win));
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Waits are bounded; a missing answer ends the run
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge clk);
        if (i == 8) begin
            failures++;
            report_and_stop();
        end
    endtask : apb
    task rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(n, q & m, x);
    endtask : rd
    task wait_win(input logic v);
        for (k = 0; k < 900 && wr_win !== v; k++) @(posedge clk);
        if (k == 900) begin
            failures++;
            report_and_stop();
        end
    endtask : wait_win
    task mr(input logic [2:0] s, input logic [13:0] a);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_MRS, {1'b0, s[2]}, s[1:0], a, 2);
    endtask : mr
    initial begin
        {clk, rst, psel, penable, pwrite, paddr, pwdata} = {1'b0, 1'b1, 43'h0};
        {failures, checks_done} = {32'h0, 32'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd("ctrl reset", 8'h00, 32'hFFFF_FFFF, 32'h0000_00B0);
        rd("status reset", 8'h04, 32'h7FFF, 32'h0);
        apb(1'b1, 8'h08, 32'hA5C3_0FF0);
        rd("pattern", 8'h08, 32'hFFFF_FFFF, 32'hA5C3_0FF0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {31'h0, e} | q, 32'h1);
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            mr(ddr_pre_pkg::MR_SEL4, 14'(k) << 11);
            rd("preamble bits", 8'h04, 32'h18, {27'h0, k[0], k[1], 3'h0});
        end
        mr(ddr_pre_pkg::MR_SEL4, 14'h1000);
        mr(ddr_pre_pkg::MR_SEL2, 14'h0018);
        rd("cwl twelve", 8'h04, 32'h1C4, 32'h0C4);
        mr(ddr_pre_pkg::MR_SEL2, 14'h0020);
        rd("cwl fourteen", 8'h04, 32'h1C4, 32'h100);
        $display("test preamble modes done");
        mr(ddr_pre_pkg::MR_SEL4, 14'h0800);
        apb(1'b1, 8'h04, 32'h3);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_RD, 2'h0, 2'h0, 14'h0, 4);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_RD, 2'h1, 2'h0, 14'h0, 5);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_RD, 2'h1, 2'h0, 14'h0, 2);
        rd("read five", 8'h04, 32'h6003, 32'h2001);
        apb(1'b1, 8'h04, 32'h3);
        rd("sticky clear", 8'h04, 32'h1, 32'h0);
        mr(ddr_pre_pkg::MR_SEL4, 14'h1000);
        apb(1'b1, 8'h00, 32'hB4);
        apb(1'b1, 8'h04, 32'h3);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_WR, 2'h0, 2'h0, 14'h0, 5);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_WR, 2'h1, 2'h0, 14'h0, 2);
        rd("crc five", 8'h04, 32'h3, 32'h0);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_WR, 2'h2, 2'h0, 14'h0, 6);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_WR, 2'h3, 2'h0, 14'h0, 2);
        rd("crc six", 8'h04, 32'h1, 32'h1);
        wait_win(1'b1);
        wait_win(1'b0);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_WR, 2'h0, 2'h0, 14'h0, 2);
        wait_win(1'b1);
        for (k = 0; k < 99 && wr_win === 1'b1; k++) @(posedge clk);
        chk("write window", k, 32'h34);
        rd("write byte", 8'h0C, 32'hFF, 32'h5A);
        $display("test spacing done");
        apb(1'b1, 8'h00, 32'hB0);
        i_ctl.issue(1'b0, 3'h0, 2'h2, 2'h3, 14'h0, 2);
        rd("act group", 8'h04, 32'h1E00, 32'h1C00);
        apb(1'b1, 8'h00, 32'hB2);
        i_ctl.issue(1'b0, 3'h0, 2'h3, 2'h1, 14'h0, 2);
        rd("x16 group", 8'h04, 32'h1E00, 32'h0A00);
        $display("test bank groups done");
        apb(1'b1, 8'h00, 32'hB0);
        mr(ddr_pre_pkg::MR_SEL4, 14'h0400);
        rd("train no mpr", 8'h04, 32'h20, 32'h0);
        apb(1'b1, 8'h00, 32'hB1);
        mr(ddr_pre_pkg::MR_SEL4, 14'h0400);
        rd("train on", 8'h04, 32'h20, 32'h20);
        chk("train pins", {dqs_oe, dqs_t_out, dqs_c_out, dq_oe, dq_out}, 32'h0BFF);
        i_ctl.issue(1'b1, ddr_pre_pkg::CMD_RD, 2'h0, 2'h0, 14'h0, 2);
        for (k = 0; k < 200 && dqs_t_out !== 1'b1; k++) @(posedge clk);
        chk("train toggle", {31'h0, dqs_t_out}, 32'h1);
        mr(ddr_pre_pkg::MR_SEL4, 14'h0);
        rd("train off", 8'h04, 32'h38, 32'h0);
        $display("test training done");
        report_and_stop();
    end
endmodule : tb
bind ddr_pre_top ddr_pre_sva i_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out),
    .dqs_oe(dqs_oe), .dq_oe(dq_oe), .dq_out(dq_out));
